// File: rtl/motor_cmd_pkg.sv
// constants and state for the motor command qualifier
// ----------------------------------------------------------------
// What this block does
// R01: forward-only limit (code 1, default) drops every reverse command and key.
// R02: reverse-only limit (code 2) drops every forward command and key.
// R03: code 3 accepts starts in both directions.
// R04: direction limit gates all sources before anything else.
// R05: edge mode: run and reset on rising edge, stop on falling edge.
// R06: level mode: terminal command active while held at active level.
// R07: edge detection is selected after reset.
// R08: in edge mode the configurer must assign some input to stop.
// R09: units setting, metric 0 default or imperial 1, also for serial reports.
// R10: metric presets 50 Hz and reports kW, Nm, degrees Celsius.
// R11: imperial presets 60 Hz and reports hp, lb.ft, degrees Fahrenheit.
// R12: changing units reloads motor data defaults for the new units.
// R13: motor data writes refused while running, accepted while stopped.
// R14: while running, refuse a set switch to a different motor.
// R15: data writes go to the selected motor set; first set after reset.
// R16: voltage 100 to 700 V, 1 V steps, default 400 V or 460 V.
// R17: frequency only 50 or 60 Hz, default follows units.
// R18: edges found against previous cycle value, one-cycle pulse each.
// R19: refused or out-of-range write changes nothing.
// ----------------------------------------------------------------
package motor_cmd_pkg;
  // rotation limit codes
  localparam logic [1:0] ROT_FWD = 2'h1;
  localparam logic [1:0] ROT_REV = 2'h2;
  localparam logic [1:0] ROT_BOTH = 2'h3;
  // terminal detection and units codes
  localparam logic MODE_LEVEL = 1'h0;
  localparam logic MODE_EDGE = 1'h1;
  localparam logic UNITS_METRIC = 1'h0;
  localparam logic UNITS_IMPERIAL = 1'h1;
  // motor sets
  localparam int NUM_MOTORS = 4;
  localparam logic [1:0] FIRST_MOTOR = 2'h0;
  // nominal voltage in volts
  localparam logic [9:0] VOLT_MIN = 10'h064;
  localparam logic [9:0] VOLT_MAX = 10'h2bc;
  localparam logic [9:0] VOLT_DEF_METRIC = 10'h190;
  localparam logic [9:0] VOLT_DEF_IMPERIAL = 10'h1cc;
  // nominal frequency in hertz
  localparam logic [6:0] FREQ_50 = 7'h32;
  localparam logic [6:0] FREQ_60 = 7'h3c;
  // bit positions of the previous terminal sample
  localparam int TB_FWD = 0;
  localparam int TB_REV = 1;
  localparam int TB_RST = 2;
  localparam int TB_STOP = 3;

  typedef struct packed {
    logic [1:0] rot;
    logic edge_mode;
    logic imperial;
    logic [1:0] sel;
    logic [NUM_MOTORS-1:0][9:0] volt;
    logic [NUM_MOTORS-1:0][6:0] freq;
    logic [3:0] prev;
    logic run_fwd;
    logic run_rev;
    logic jog_forward_key;
    logic jog_reverse_key;
    logic reset_cmd;
    logic stop_cmd;
    logic refused;
    logic [9:0] volt_out;
    logic [6:0] freq_out;
  } qual_state_t;
endpackage : motor_cmd_pkg

// File: rtl/motor_command_qualifier.sv
// motor command qualifier: direction limit, terminal detection, units and motor data
`timescale 1ns/10ps
`default_nettype none
module motor_command_qualifier
  import motor_cmd_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // motor state
  input wire logic i_motor_running,
  // terminal strip inputs, levels
  input wire logic i_term_fwd,
  input wire logic i_term_rev,
  input wire logic i_term_reset,
  input wire logic i_term_stop,
  // panel keys, one-cycle presses
  input wire logic i_key_fwd,
  input wire logic i_key_rev,
  input wire logic i_key_jog_forward_key,
  input wire logic i_key_jog_reverse_key,
  input wire logic i_key_reset,
  // serial link commands, one-cycle
  input wire logic i_ser_fwd,
  input wire logic i_ser_rev,
  // configuration writes
  input wire logic i_rot_wr,
  input wire logic [1:0] i_rot,
  input wire logic i_mode_wr,
  input wire logic i_mode,
  input wire logic i_units_wr,
  input wire logic i_units,
  input wire logic i_sel_wr,
  input wire logic [1:0] i_sel,
  input wire logic i_volt_wr,
  input wire logic [9:0] i_volt,
  input wire logic i_freq_wr,
  input wire logic [6:0] i_freq,
  // qualified commands
  output logic o_run_fwd,
  output logic o_run_rev,
  output logic o_jog_forward_key,
  output logic o_jog_reverse_key,
  output logic o_reset_cmd,
  output logic o_stop_cmd,
  // settings and status
  output logic [1:0] o_rotation_limit,
  output logic o_edge_mode,
  output logic o_imperial_units,
  output logic [1:0] o_motor_sel,
  output logic [9:0] o_motor_volt,
  output logic [6:0] o_motor_freq,
  output logic o_write_refused
);

  qual_state_t s;
  qual_state_t next_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic allow_fwd;
    logic allow_rev;
    logic t_fwd;
    logic t_rev;
    logic t_rst;
    logic t_stop;
    logic [9:0] dv;
    logic [6:0] df;
    allow_fwd = 1'b0;
    allow_rev = 1'b0;
    t_fwd = 1'b0;
    t_rev = 1'b0;
    t_rst = 1'b0;
    t_stop = 1'b0;
    dv = VOLT_DEF_METRIC;
    df = FREQ_50;
    next_s = s;
    next_s.refused = 1'b0;
    // direction gate sits ahead of every source
    allow_fwd = (s.rot == ROT_FWD) || (s.rot == ROT_BOTH); // R02 R03 R04
    allow_rev = (s.rot == ROT_REV) || (s.rot == ROT_BOTH); // R01 R03 R04
    // terminal detection, previous sample gives the edge
    if (s.edge_mode == MODE_EDGE) begin
      t_fwd = i_term_fwd & ~s.prev[TB_FWD]; // R05 R18
      t_rev = i_term_rev & ~s.prev[TB_REV]; // R05 R18
      t_rst = i_term_reset & ~s.prev[TB_RST]; // R05 R18
      t_stop = ~i_term_stop & s.prev[TB_STOP]; // R05 R18
    end else begin
      t_fwd = i_term_fwd; // R06
      t_rev = i_term_rev; // R06
      t_rst = i_term_reset; // R06
      t_stop = ~i_term_stop; // R06
    end
    next_s.prev = {i_term_stop, i_term_reset, i_term_rev, i_term_fwd};
    next_s.run_fwd = allow_fwd & (t_fwd | i_key_fwd | i_ser_fwd); // R02 R04
    next_s.run_rev = allow_rev & (t_rev | i_key_rev | i_ser_rev); // R01 R04
    next_s.jog_forward_key = allow_fwd & i_key_jog_forward_key; // R02
    next_s.jog_reverse_key = allow_rev & i_key_jog_reverse_key; // R01
    next_s.reset_cmd = t_rst | i_key_reset;
    next_s.stop_cmd = t_stop;
    // code 0 is no legal limit, so it is refused
    if (i_rot_wr) begin
      if (i_rot != 2'h0) next_s.rot = i_rot;
      else next_s.refused = 1'b1; // R19
    end
    if (i_mode_wr) next_s.edge_mode = i_mode;
    // a units swap rewrites motor data, so it is locked while running too
    if (i_units_wr && (i_units != s.imperial)) begin
      if (i_motor_running) begin
        next_s.refused = 1'b1; // R13 R19
      end else begin
        next_s.imperial = i_units; // R09
        dv = i_units ? VOLT_DEF_IMPERIAL : VOLT_DEF_METRIC; // R16
        df = i_units ? FREQ_60 : FREQ_50; // R10 R11 R17
        for (int m = 0; m < NUM_MOTORS; m++) begin
          next_s.volt[m] = dv; // R12
          next_s.freq[m] = df; // R12
        end
      end
    end
    // a set switch may not change motor under load
    if (i_sel_wr) begin
      if (i_motor_running && (i_sel != s.sel)) next_s.refused = 1'b1; // R14 R19
      else next_s.sel = i_sel;
    end
    // data lands in the set selected before this cycle
    if (i_volt_wr) begin
      if (i_motor_running || (i_volt < VOLT_MIN) || (i_volt > VOLT_MAX)) begin
        next_s.refused = 1'b1; // R13 R16 R19
      end else begin
        next_s.volt[s.sel] = i_volt; // R15 R16
      end
    end
    if (i_freq_wr) begin
      if (i_motor_running || ((i_freq != FREQ_50) && (i_freq != FREQ_60))) begin
        next_s.refused = 1'b1; // R13 R17 R19
      end else begin
        next_s.freq[s.sel] = i_freq; // R15 R17
      end
    end
    // outputs show the set selected after this cycle
    next_s.volt_out = next_s.volt[next_s.sel];
    next_s.freq_out = next_s.freq[next_s.sel];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // prev of stop resets low so no false stop edge follows reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s.rot <= ROT_FWD; // R01
      s.edge_mode <= MODE_EDGE; // R07
      s.imperial <= UNITS_METRIC; // R09
      s.sel <= FIRST_MOTOR; // R15
      for (int m = 0; m < NUM_MOTORS; m++) begin
        s.volt[m] <= VOLT_DEF_METRIC;
        s.freq[m] <= FREQ_50; // R10
      end
      s.prev <= 4'h0;
      s.run_fwd <= 1'b0;
      s.run_rev <= 1'b0;
      s.jog_forward_key <= 1'b0;
      s.jog_reverse_key <= 1'b0;
      s.reset_cmd <= 1'b0;
      s.stop_cmd <= 1'b0;
      s.refused <= 1'b0;
      s.volt_out <= VOLT_DEF_METRIC;
      s.freq_out <= FREQ_50;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign o_run_fwd = s.run_fwd;
  assign o_run_rev = s.run_rev;
  assign o_jog_forward_key = s.jog_forward_key;
  assign o_jog_reverse_key = s.jog_reverse_key;
  assign o_reset_cmd = s.reset_cmd;
  assign o_stop_cmd = s.stop_cmd;
  assign o_rotation_limit = s.rot;
  assign o_edge_mode = s.edge_mode;
  assign o_imperial_units = s.imperial;
  assign o_motor_sel = s.sel;
  assign o_motor_volt = s.volt_out;
  assign o_motor_freq = s.freq_out;
  assign o_write_refused = s.refused;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // helper: stopped and no write that moves the shown set or reloads every set
  logic stopped_solo;
  assign stopped_solo = !i_motor_running && !i_sel_wr && !i_units_wr;

  // multi-step behaviours used below
  sequence seq_stopped_units_imp;
    i_units_wr && i_units && !s.imperial && !i_motor_running && !i_volt_wr && !i_freq_wr && !i_sel_wr;
  endsequence
  sequence seq_imp_defaults;
    o_imperial_units && (o_motor_volt == VOLT_DEF_IMPERIAL) && (o_motor_freq == FREQ_60);
  endsequence
  sequence seq_stopped_units_met;
    i_units_wr && !i_units && s.imperial && !i_motor_running && !i_volt_wr && !i_freq_wr && !i_sel_wr;
  endsequence
  sequence seq_met_defaults;
    !o_imperial_units && (o_motor_volt == VOLT_DEF_METRIC) && (o_motor_freq == FREQ_50);
  endsequence
  sequence seq_fwd_held;
    (i_term_fwd && !i_key_fwd && !i_ser_fwd) [*2];
  endsequence
  sequence seq_rst_held;
    (i_term_reset && !i_key_reset) [*2];
  endsequence

  // direction gate and limit setting
  AST_FWD_ONLY: assert property (o_run_rev || o_jog_reverse_key |-> $past(s.rot) != ROT_FWD) // R01
    else $error("reverse command passed a forward-only limit");
  AST_REV_ONLY: assert property (o_run_fwd || o_jog_forward_key |-> $past(s.rot) != ROT_REV) // R02
    else $error("forward command passed a reverse-only limit");
  AST_BOTH_DIR: assert property ((s.rot == ROT_BOTH) && i_ser_rev && i_key_fwd // R03
    |=> o_run_rev && o_run_fwd)
    else $error("both-direction limit dropped a start");
  AST_ROT_TAKE: assert property (i_rot_wr && (i_rot != 2'h0) // R03
    |=> o_rotation_limit == $past(i_rot))
    else $error("legal rotation limit not stored");
  AST_ROT_ZERO: assert property (i_rot_wr && (i_rot == 2'h0) // R19
    |=> o_write_refused && $stable(o_rotation_limit))
    else $error("rotation code zero not refused");
  AST_KEEP_LIMIT: assert property (!i_rot_wr |=> $stable(o_rotation_limit)) // R19
    else $error("rotation limit moved without a write");

  // terminal detection; a mode write in the watched cycle would change the next answer
  // so the edge checks that span cycles leave those cycles out
  AST_EDGE_ONCE: assert property ((s.edge_mode && !i_mode_wr) throughout seq_fwd_held |=> !o_run_fwd) // R05
    else $error("held terminal forward repeated in edge mode");
  AST_RST_ONCE: assert property ((s.edge_mode && !i_mode_wr) throughout seq_rst_held // R18
    |=> !o_reset_cmd)
    else $error("held terminal reset repeated in edge mode");
  AST_RST_RISE: assert property (s.edge_mode && !s.prev[TB_RST] && i_term_reset |=> o_reset_cmd) // R05
    else $error("reset rising edge not taken");
  AST_STOP_FALL: assert property (s.edge_mode && !i_mode_wr && s.prev[TB_STOP] && !i_term_stop // R18
    |=> o_stop_cmd ##1 !o_stop_cmd)
    else $error("stop edge not a single pulse");
  AST_LEVEL_RUN: assert property (!s.edge_mode && (s.rot != ROT_REV) && i_term_fwd // R06
    |=> o_run_fwd)
    else $error("level mode dropped a held forward input");
  AST_LEVEL_STOP: assert property (!s.edge_mode && !i_term_stop |=> o_stop_cmd) // R06
    else $error("level mode dropped a held stop input");
  AST_MODE_TAKE: assert property (i_mode_wr |=> o_edge_mode == $past(i_mode)) // R05
    else $error("detection mode not stored");
  AST_AFTER_RST: assert property ($past(i_rst) |-> o_edge_mode && (o_motor_sel == FIRST_MOTOR)) // R07
    else $error("edge mode or first motor set missing after reset");

  // units
  AST_UNITS_IMP: assert property (seq_stopped_units_imp |=> seq_imp_defaults) // R12
    else $error("imperial units did not load imperial defaults");
  AST_UNITS_MET: assert property (seq_stopped_units_met |=> seq_met_defaults) // R10
    else $error("metric units did not load metric defaults");
  AST_UNITS_TAKE: assert property (!i_motor_running && i_units_wr // R09
    |=> o_imperial_units == $past(i_units))
    else $error("units setting not stored while stopped");
  AST_UNITS_RUN: assert property (i_motor_running && i_units_wr && (i_units != s.imperial) // R13
    |=> o_write_refused && $stable(o_imperial_units))
    else $error("units change taken while running");

  // motor data
  AST_RUN_LOCK: assert property (i_motor_running && !i_sel_wr && !i_units_wr && i_volt_wr // R13
    |=> o_write_refused && $stable(o_motor_volt))
    else $error("voltage write taken while running");
  AST_FREQ_LOCK: assert property (i_motor_running && !i_sel_wr && !i_units_wr && i_freq_wr // R13
    |=> o_write_refused && $stable(o_motor_freq))
    else $error("frequency write taken while running");
  AST_SET_LOCK: assert property (i_motor_running && i_sel_wr && (i_sel != s.sel) // R14
    |=> $stable(o_motor_sel) && o_write_refused)
    else $error("set switch to another motor taken while running");
  AST_SEL_TAKE: assert property (!i_motor_running && i_sel_wr |=> o_motor_sel == $past(i_sel)) // R15
    else $error("set switch not taken while stopped");
  AST_VOLT_TAKE: assert property (stopped_solo && i_volt_wr && (i_volt >= VOLT_MIN) && (i_volt <= VOLT_MAX) // R15
    |=> o_motor_volt == $past(i_volt))
    else $error("legal voltage write not stored");
  AST_VOLT_RANGE: assert property (stopped_solo && i_volt_wr && (i_volt > VOLT_MAX) // R16
    |=> $stable(o_motor_volt) && o_write_refused)
    else $error("out-of-range voltage stored");
  AST_VOLT_LOW: assert property (stopped_solo && i_volt_wr && (i_volt < VOLT_MIN) // R16
    |=> $stable(o_motor_volt) && o_write_refused)
    else $error("too low voltage stored");
  AST_FREQ_LEGAL: assert property (stopped_solo && i_freq_wr && (i_freq == FREQ_60) // R17
    |=> o_motor_freq == FREQ_60)
    else $error("legal frequency write not stored");
  AST_FREQ_RANGE: assert property (stopped_solo && i_freq_wr && (i_freq != FREQ_50) && (i_freq != FREQ_60) // R17
    |=> $stable(o_motor_freq) && o_write_refused)
    else $error("illegal frequency stored");
  AST_NO_REFUSE: assert property (!i_rot_wr && !i_units_wr && !i_sel_wr && !i_volt_wr && !i_freq_wr // R19
    |=> !o_write_refused)
    else $error("refusal flagged without a write");
endmodule : motor_command_qualifier
`default_nettype wire

// File: tb/cmd_source_model.sv
// far-side model: terminal strip, panel keys and serial master
`timescale 1ns/10ps
`default_nettype none
module cmd_source_model (
  // wanted activity from the bench, stop bit means stop asserted
  input wire logic [10:0] i_want,
  // terminal strip {stop, reset, rev, fwd}, keys, serial
  output logic [3:0] o_term,
  output logic [4:0] o_key,
  output logic [1:0] o_ser
);
  // stop terminal is always wired and idles high, so edge mode has a way to stop
  assign o_term = {~i_want[10], i_want[9:7]};
  // keys and serial commands pass through as the bench sets them
  assign o_key = i_want[6:2];
  assign o_ser = i_want[1:0];
endmodule : cmd_source_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the motor command qualifier
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import motor_cmd_pkg::*;
  // ----------------------------------------
  // stimulus and observation signals
  // ----------------------------------------
  logic i_mclk = 1'h0;
  logic i_rst = 1'h1;
  logic i_motor_running = 1'h0;
  logic [10:0] want = 11'h000;
  logic [5:0] wr = 6'h00; // rot, mode, units, sel, volt, freq
  logic [9:0] wd = 10'h000;
  logic [3:0] term;
  logic [4:0] key;
  logic [1:0] ser;
  logic [5:0] cmd; // run_fwd, run_rev, jog_forward_key, jog_reverse_key, reset, stop
  logic [1:0] lim, sel, rr;
  logic edge_m, imp, refused;
  logic [9:0] volt;
  logic [6:0] freq;
  logic [5:0] expc;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  // even entries are forward sources, odd entries reverse sources
  logic [10:0] src [8] = '{11'h040, 11'h020, 11'h010, 11'h008, 11'h002, 11'h001, 11'h080, 11'h100};
  logic [5:0] hit [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h20, 6'h10, 6'h20, 6'h10};

  cmd_source_model i_cmd_source_model (.i_want(want), .o_term(term), .o_key(key), .o_ser(ser));

  motor_command_qualifier i_motor_command_qualifier (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_motor_running(i_motor_running),
    .i_term_fwd(term[0]), .i_term_rev(term[1]), .i_term_reset(term[2]), .i_term_stop(term[3]),
    .i_key_fwd(key[4]), .i_key_rev(key[3]), .i_key_jog_forward_key(key[2]), .i_key_jog_reverse_key(key[1]),
    .i_key_reset(key[0]), .i_ser_fwd(ser[1]), .i_ser_rev(ser[0]),
    .i_rot_wr(wr[5]), .i_rot(wd[1:0]), .i_mode_wr(wr[4]), .i_mode(wd[0]),
    .i_units_wr(wr[3]), .i_units(wd[0]), .i_sel_wr(wr[2]), .i_sel(wd[1:0]),
    .i_volt_wr(wr[1]), .i_volt(wd), .i_freq_wr(wr[0]), .i_freq(wd[6:0]),
    .o_run_fwd(cmd[5]), .o_run_rev(cmd[4]), .o_jog_forward_key(cmd[3]), .o_jog_reverse_key(cmd[2]),
    .o_reset_cmd(cmd[1]), .o_stop_cmd(cmd[0]), .o_rotation_limit(lim), .o_edge_mode(edge_m),
    .o_imperial_units(imp), .o_motor_sel(sel), .o_motor_volt(volt), .o_motor_freq(freq),
    .o_write_refused(refused)
  );

  // 25 MHz clock
  always #20 i_mclk = ~i_mclk;

  // hang guard, the whole sequence needs about 115 cycles
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one write strobe for one cycle; results are settled at the following falling edge
  task automatic cfg(input logic [5:0] w, input logic [9:0] d);
    @(negedge i_mclk);
    wr = w;
    wd = d;
    @(negedge i_mclk);
    wr = 6'h00;
  endtask : cfg

  // set command levels after a falling edge; outputs show them one edge later
  task automatic drv(input logic [10:0] v);
    @(negedge i_mclk);
    want = v;
  endtask : drv

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'h0;
    chk("settings", {4'h0, lim, edge_m, imp, sel}, 10'h018);
    chk("volt", volt, 10'h190);
    chk("freq", 10'(freq), 10'h032);
    $display("test reset defaults done");
    // every source against every direction limit
    for (int r = 1; r < 4; r++) begin
      rr = 2'(r);
      cfg(6'h20, 10'(rr));
      chk("limit", 10'(lim), 10'(rr));
      for (int k = 0; k < 8; k++) begin
        drv(src[k]);
        drv(11'h000);
        expc = ((k % 2 == 0) ? rr[0] : rr[1]) ? hit[k] : 6'h00;
        chk("gated cmd", 10'(cmd), 10'(expc));
      end
    end
    drv(11'h041);
    drv(11'h000);
    chk("both dir", 10'(cmd), 10'h030);
    cfg(6'h20, 10'h000);
    chk("refused", 10'(refused), 10'h001);
    chk("limit", 10'(lim), 10'h003);
    $display("test direction limit done");
    drv(11'h280);
    drv(11'h280);
    chk("edge run", 10'(cmd), 10'h022);
    drv(11'h400);
    chk("edge held", 10'(cmd), 10'h000);
    drv(11'h400);
    chk("edge stop", 10'(cmd), 10'h001);
    drv(11'h000);
    chk("stop once", 10'(cmd), 10'h000);
    cfg(6'h10, 10'h000);
    chk("mode", 10'(edge_m), 10'h000);
    drv(11'h480);
    drv(11'h480);
    drv(11'h480);
    chk("level held", 10'(cmd), 10'h021);
    drv(11'h000);
    drv(11'h000);
    chk("level off", 10'(cmd), 10'h000);
    cfg(6'h10, 10'h001);
    $display("test terminal detection done");
    cfg(6'h02, 10'h0e6);
    chk("volt", volt, 10'h0e6);
    cfg(6'h02, 10'h063);
    chk("refused", 10'(refused), 10'h001);
    cfg(6'h02, 10'h2bd);
    chk("volt", volt, 10'h0e6);
    cfg(6'h02, 10'h2bc);
    chk("volt", volt, 10'h2bc);
    cfg(6'h01, 10'h037);
    chk("freq", 10'(freq), 10'h032);
    cfg(6'h01, 10'h03c);
    chk("freq", 10'(freq), 10'h03c);
    cfg(6'h04, 10'h001);
    chk("set1 volt", volt, 10'h190);
    cfg(6'h04, 10'h000);
    chk("set0 volt", volt, 10'h2bc);
    $display("test motor data done");
    @(negedge i_mclk);
    i_motor_running = 1'h1;
    cfg(6'h02, 10'h12c);
    chk("run volt", volt, 10'h2bc);
    cfg(6'h01, 10'h032);
    chk("run freq refused", 10'(refused), 10'h001);
    chk("run freq", 10'(freq), 10'h03c);
    cfg(6'h04, 10'h001);
    chk("run sel", 10'(sel), 10'h000);
    cfg(6'h04, 10'h000);
    chk("run same sel", 10'(refused), 10'h000);
    cfg(6'h08, 10'h001);
    chk("run units", 10'(imp), 10'h000);
    @(negedge i_mclk);
    i_motor_running = 1'h0;
    $display("test running lock done");
    cfg(6'h08, 10'h001);
    chk("imp", 10'(imp), 10'h001);
    chk("imp volt", volt, 10'h1cc);
    chk("imp freq", 10'(freq), 10'h03c);
    cfg(6'h04, 10'h001);
    chk("set1 imp volt", volt, 10'h1cc);
    cfg(6'h08, 10'h000);
    chk("metric volt", volt, 10'h190);
    chk("metric freq", 10'(freq), 10'h032);
    $display("test units done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
